// >>> rtl/djk_dual.v
// Two independent JK storage channels, each stepped by the falling edge
// of its own clock pin, with active-low direct set and clear.
// Assumes all channel pins are asynchronous to the 20 MHz system clock.
// Outputs follow a pin change five system clocks later.
`timescale 1ns/1ns
`include "djk_dual_regs.vh"
module djk_dual (
  // System
  input  wire clock,
  input  wire sys_rst,
  input  wire clk_en,
  // Channel 1 pins
  input  wire j_1,
  input  wire k_1,
  input  wire falling_edge_clock_1,
  input  wire set_n_1,
  input  wire clear_n_1,
  // Channel 2 pins
  input  wire j_2,
  input  wire k_2,
  input  wire falling_edge_clock_2,
  input  wire set_n_2,
  input  wire clear_n_2,
  // Channel 1 outputs
  output wire q_1,
  output wire q_bar_1,
  // Channel 2 outputs
  output wire q_2,
  output wire q_bar_2
);

  // Fixed by the pin list, so not a parameter
  localparam NUM_CH = `DJK_NUM_CH;

  // Packed per-channel pins, bit n is channel n+1
  wire [NUM_CH-1:0] j_pin;
  wire [NUM_CH-1:0] k_pin;
  wire [NUM_CH-1:0] clk_pin;
  wire [NUM_CH-1:0] set_n_pin;
  wire [NUM_CH-1:0] clear_n_pin;
  wire [NUM_CH-1:0] q_out;
  wire [NUM_CH-1:0] q_bar_out;

  assign j_pin       = {j_2, j_1};
  assign k_pin       = {k_2, k_1};
  assign clk_pin     = {falling_edge_clock_2, falling_edge_clock_1};
  assign set_n_pin   = {set_n_2, set_n_1};
  assign clear_n_pin = {clear_n_2, clear_n_1};

  assign q_1     = q_out[0];
  assign q_bar_1 = q_bar_out[0];
  assign q_2     = q_out[1];
  assign q_bar_2 = q_bar_out[1];

  // Accepted pin values
  wire [NUM_CH-1:0] j_s;
  wire [NUM_CH-1:0] k_s;
  wire [NUM_CH-1:0] clk_s;
  wire [NUM_CH-1:0] set_n_s;
  wire [NUM_CH-1:0] clear_n_s;

  // Every pin gets the same depth, so clock and data stay aligned
  djk_sync #(
    .WIDTH   (NUM_CH),
    .RST_VAL ({NUM_CH{`DJK_RST_CLK}})
  ) u_sync_clk (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .pin_in    (clk_pin),
    .value_out (clk_s)
  );

  djk_sync #(
    .WIDTH   (NUM_CH),
    .RST_VAL ({NUM_CH{`DJK_RST_JK}})
  ) u_sync_j (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .pin_in    (j_pin),
    .value_out (j_s)
  );

  djk_sync #(
    .WIDTH   (NUM_CH),
    .RST_VAL ({NUM_CH{`DJK_RST_JK}})
  ) u_sync_k (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .pin_in    (k_pin),
    .value_out (k_s)
  );

  // Set and clear idle high, so reset leaves both overrides off
  djk_sync #(
    .WIDTH   (NUM_CH),
    .RST_VAL ({NUM_CH{`DJK_RST_SET_N}})
  ) u_sync_set_n (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .pin_in    (set_n_pin),
    .value_out (set_n_s)
  );

  djk_sync #(
    .WIDTH   (NUM_CH),
    .RST_VAL ({NUM_CH{`DJK_RST_CLEAR_N}})
  ) u_sync_clear_n (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .pin_in    (clear_n_pin),
    .value_out (clear_n_s)
  );

  // One private copy of the storage logic per channel
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
      reg       clk_prev_q;
      reg       j_prev_q;
      reg       k_prev_q;
      reg       state_q;
      reg       state_d;
      reg       q_q;
      reg       q_d;
      reg       q_bar_q;
      reg       q_bar_d;
      wire      fall;
      wire      set_act;
      wire      clear_act;
      wire [1:0] jk_sel;

      assign set_act   = ~set_n_s[ch];
      assign clear_act = ~clear_n_s[ch];

      // Only a high-to-low step counts; rising or steady does nothing
      assign fall = clk_prev_q & ~clk_s[ch];

      // Values held one cycle before the fall, so late data changes miss
      assign jk_sel = {j_prev_q, k_prev_q};

      // Pin history; reset clock level low so no false fall follows reset
      always @(posedge clock) begin
        if (sys_rst) begin
          clk_prev_q <= `DJK_RST_CLK;
          j_prev_q   <= `DJK_RST_JK;
          k_prev_q   <= `DJK_RST_JK;
        end else if (clk_en) begin
          clk_prev_q <= clk_s[ch];
          j_prev_q   <= j_s[ch];
          k_prev_q   <= k_s[ch];
        end
      end

      // Stored state and output pair, frozen while clk_en is low
      always @(posedge clock) begin
        if (sys_rst) begin
          state_q    <= `DJK_RST_STATE;
          q_q        <= `DJK_RST_STATE;
          q_bar_q    <= ~`DJK_RST_STATE;
        end else if (clk_en) begin
          state_q    <= state_d;
          q_q        <= q_d;
          q_bar_q    <= q_bar_d;
        end
      end

      // Next stored state
      always @* begin
        state_d = state_q;
        if (set_act) begin
          // Set wins in storage when both are low; outputs still both high
          state_d = 1'b1;
        end else if (clear_act) begin
          state_d = 1'b0;
        end else if (fall) begin
          case (jk_sel)
            `DJK_JK_HOLD:   state_d = state_q;
            `DJK_JK_LOW:    state_d = 1'b0;
            `DJK_JK_HIGH:   state_d = 1'b1;
            `DJK_JK_TOGGLE: state_d = ~state_q;
            default:        state_d = state_q;
          endcase
        end
      end

      // Registered, so both outputs move on one system edge
      // Output pair; overrides act without any clock-pin edge
      always @* begin
        if (set_act && clear_act) begin
          {q_d, q_bar_d} = `DJK_OUT_BOTH;
        end else if (set_act) begin
          {q_d, q_bar_d} = `DJK_OUT_SET;
        end else if (clear_act) begin
          {q_d, q_bar_d} = `DJK_OUT_CLEAR;
        end else begin
          q_d     = state_d;
          q_bar_d = ~state_d;
        end
      end

      assign q_out[ch]     = q_q;
      assign q_bar_out[ch] = q_bar_q;
    end
  endgenerate

endmodule // djk_dual

// >>> rtl/djk_dual_regs.vh
// Constants for the dual JK storage block: sampling depth,
// reset values and output encodings.
// Assumes inclusion by bare name from the design files.
`ifndef DJK_DUAL_REGS_VH
`define DJK_DUAL_REGS_VH

// Pin sampling depth (three flops, last two must agree)
`define DJK_SYNC_STAGES      3

// Number of independent channels
`define DJK_NUM_CH           2

// Reset values of sampled pins
`define DJK_RST_CLK          1'h0
`define DJK_RST_JK           1'h0
`define DJK_RST_SET_N        1'h1
`define DJK_RST_CLEAR_N      1'h1

// Reset value of the stored state
`define DJK_RST_STATE        1'h0

// Output pair for each override case {true, complement}
`define DJK_OUT_BOTH         2'h3
`define DJK_OUT_SET          2'h2
`define DJK_OUT_CLEAR        2'h1

// Bit positions of the JK select field {j, k}
`define DJK_SEL_J            1
`define DJK_SEL_K            0

// JK select codes
`define DJK_JK_HOLD          2'h0
`define DJK_JK_LOW           2'h1
`define DJK_JK_HIGH          2'h2
`define DJK_JK_TOGGLE        2'h3

`endif

// >>> rtl/djk_sync.v
// Pin sampler: three flops per bit, value accepted once stages two
// and three agree.
// Assumes asynchronous pins and one system clock.
`timescale 1ns/1ns
module djk_sync #(
  parameter             WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // System
  input  wire             clock,
  input  wire             sys_rst,
  input  wire             clk_en,
  // Pins in
  input  wire [WIDTH-1:0] pin_in,
  // Accepted value out
  output wire [WIDTH-1:0] value_out
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;
  reg [WIDTH-1:0] stage3_q;
  reg [WIDTH-1:0] value_q;
  reg [WIDTH-1:0] value_d;
  integer         i;

  // Stage one feeds stage two only
  always @(posedge clock) begin
    if (sys_rst) begin
      stage1_q <= RST_VAL;
      stage2_q <= RST_VAL;
      stage3_q <= RST_VAL;
      value_q  <= RST_VAL;
    end else if (clk_en) begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      value_q  <= value_d;
    end
  end

  // Accept a bit only while the last two stages match
  always @* begin
    value_d = value_q;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (stage2_q[i] == stage3_q[i]) begin
        value_d[i] = stage3_q[i];
      end
    end
  end

  assign value_out = value_q;

endmodule // djk_sync

// >>> tb/djk_dual_assertions.sv
// Checker on the dual JK block ports, channel 1 only.
// Assumes clk_en drops only while channel 1 pins stand still.
`timescale 1ns/1ns
module djk_dual_assertions (
  // System
  input logic clock,
  input logic sys_rst,
  // Channel 1 pins
  input logic j_1,
  input logic k_1,
  input logic falling_edge_clock_1,
  input logic set_n_1,
  input logic clear_n_1,
  // Channel 1 outputs
  input logic q_1,
  input logic q_bar_1
);
  wire fc = falling_edge_clock_1;
  wire ok = set_n_1 & clear_n_1;
  wire cl = set_n_1 & !clear_n_1;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Six high samples then two low, data steady throughout
  sequence s_fall(bit jv, bit kv);
    (ok && j_1 == jv && k_1 == kv && fc)[*6] ##1 (ok && j_1 == jv && k_1 == kv && !fc)[*2];
  endsequence
  // Long low, then long high: a rise only
  sequence s_rise;
    (ok && !fc)[*6] ##1 (ok && fc)[*6];
  endsequence
  a_jk_hold: assert property (s_fall(0, 0) |-> ##4 q_1 == $past(q_1, 4)) else $error("hold moved");
  a_jk_low: assert property (s_fall(0, 1) |-> ##4 !q_1) else $error("load low");
  a_jk_high: assert property (s_fall(1, 0) |-> ##4 q_1) else $error("load high");
  a_jk_toggle: assert property (s_fall(1, 1) |-> ##4 q_1 != $past(q_1, 4)) else $error("toggle");
  a_rise_inert: assert property (s_rise |-> q_1 == $past(q_1, 6)) else $error("rise acted");
  a_set_high: assert property ((!set_n_1 && clear_n_1)[*6] |-> q_1 && !q_bar_1) else $error("set");
  a_clear_low: assert property (cl[*6] |-> !q_1 && q_bar_1) else $error("clear");
  a_both_high: assert property ((!set_n_1 && !clear_n_1)[*6] |-> q_1 && q_bar_1) else $error("both");
  a_fall_held: assert property ((cl && fc)[*2] ##1 (cl && !fc)[*6] |-> !q_1) else $error("fall acted");
endmodule // djk_dual_assertions
bind djk_dual djk_dual_assertions i_djk_dual_assertions (.*);

// >>> tb/djk_dual_tb_top.sv
// Bench for the dual JK block, pins driven through the far model.
// Assumes five system clocks from pin to output.
`timescale 1ns/1ns
`include "djk_dual_regs.vh"
module djk_dual_tb_top;
  logic       clock      = 1'h0;
  logic       sys_rst    = 1'h1;
  logic       clk_en     = 1'h1;
  wire  [4:0] p1;
  wire  [4:0] p2;
  wire        q_1;
  wire        q_bar_1;
  wire        q_2;
  wire        q_bar_2;
  int         error_cnt  = 0;
  int         n_compared = 0;
  always #25 clock = ~clock;
  djk_far i_djk_far (.clock(clock), .pins_1(p1), .pins_2(p2));
  djk_dual i_djk_dual (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .j_1(p1[4]), .k_1(p1[3]), .falling_edge_clock_1(p1[2]), .set_n_1(p1[1]), .clear_n_1(p1[0]),
    .j_2(p2[4]), .k_2(p2[3]), .falling_edge_clock_2(p2[2]), .set_n_2(p2[1]), .clear_n_2(p2[0]),
    .q_1(q_1), .q_bar_1(q_bar_1), .q_2(q_2), .q_bar_2(q_bar_2));
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %b want %b", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_async;
    i_djk_far.put(2, 5'h01, 6);
    chk({q_2, q_bar_2}, `DJK_OUT_SET);
    chk({q_1, q_bar_1}, `DJK_OUT_CLEAR);
    i_djk_far.put(2, 5'h03, 1);
    i_djk_far.put(1, 5'h05, 6);
    chk({q_1, q_bar_1}, `DJK_OUT_SET);
    i_djk_far.put(1, 5'h0E, 6);
    chk({q_1, q_bar_1}, `DJK_OUT_CLEAR);
    i_djk_far.put(1, 5'h12, 8);
    chk({q_1, q_bar_1}, `DJK_OUT_CLEAR);
    i_djk_far.put(1, 5'h00, 6);
    chk({q_1, q_bar_1}, `DJK_OUT_BOTH);
    i_djk_far.free(1);
    chk({q_1, q_bar_1}, `DJK_OUT_SET);
    $display("async test done");
  endtask
  task automatic t_jk;
    logic [1:0] code [6] = '{`DJK_JK_HOLD, `DJK_JK_LOW, `DJK_JK_HOLD, `DJK_JK_HIGH, `DJK_JK_TOGGLE, `DJK_JK_TOGGLE};
    logic [5:0] want = 6'h29;
    for (int i = 0; i < 6; i++) begin
      i_djk_far.fall(1, code[i]);
      chk({q_1, q_bar_1}, {want[i], ~want[i]});
      chk({q_2, q_bar_2}, `DJK_OUT_SET);
    end
    // Rise with toggle data must leave the state alone
    i_djk_far.put(1, 5'h1F, 6);
    chk({q_1, q_bar_1}, {want[5], ~want[5]});
    $display("jk test done");
  endtask
  // Channel 2 clear must wait while clk_en is low, then act
  task automatic t_freeze;
    @(posedge clock);
    clk_en <= 1'h0;
    i_djk_far.put(2, 5'h02, 6);
    chk({q_2, q_bar_2}, `DJK_OUT_SET);
    @(posedge clock);
    clk_en <= 1'h1;
    repeat (6) @(posedge clock);
    #1;
    chk({q_2, q_bar_2}, `DJK_OUT_CLEAR);
    $display("freeze test done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    #1;
    chk({q_1, q_bar_1}, {`DJK_RST_STATE, ~`DJK_RST_STATE});
    t_async;
    t_jk;
    t_freeze;
    test_done;
  end
  // Tests take about 170 clocks
  initial begin
    repeat (2000) @(posedge clock);
    error_cnt++;
    test_done;
  end
endmodule // djk_dual_tb_top

// >>> tb/djk_far.sv
// Surrounding logic: drives data, clock, set, clear per channel.
// Assumes callers run off the rising system clock edge.
`timescale 1ns/1ns
module djk_far (
  // System
  input  logic       clock,
  // Pins {j, k, clock, set_n, clear_n}
  output logic [4:0] pins_1 = 5'h03,
  output logic [4:0] pins_2 = 5'h03
);
  task automatic put(input int ch, input logic [4:0] v, input int n);
    @(posedge clock);
    if (ch == 1) pins_1 <= v;
    else pins_2 <= v;
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Data held well before and after the fall
  task automatic fall(input int ch, input logic [1:0] jk);
    put(ch, {jk, 3'h7}, 6);
    put(ch, {jk, 3'h3}, 8);
  endtask
  // Both-low left one input at a time, never together
  task automatic free(input int ch);
    put(ch, 5'h01, 2);
    put(ch, 5'h03, 6);
  endtask
endmodule // djk_far
